// ### dv/adc_mode_calibration_control_asserts.sv
`timescale 1ns/1ps
module adc_mode_calibration_control_asserts #(
  parameter [11:0] NOTCH_CYCLES = 12'h200
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire transmitFrameN,
  input wire receiveFrameN,
  input wire registerSelectLine,
  input wire serialDataOe,
  input wire resultReadyN,
  input wire [2:0] gainCode,
  input wire [7:0] pgaGain,
  input wire inputSelect,
  input wire sleepRequest,
  input wire outputWordSize,
  input wire [11:0] notchCode,
  input wire [2:0] modeSelect
);
  reg [15:0] calCnt_r;
  wire calMode = modeSelect != 3'h0 && modeSelect < 3'h5;
  // cycles spent in the running one-shot calibration
  always @(posedge clk) begin
    if (!rst_n || !calMode) calCnt_r <= 16'h0000;
    else calCnt_r <= calCnt_r + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence seqCalRun; calMode; endsequence
  sequence seqCalEnd; modeSelect == 3'h0; endsequence
  a_reset_vals: assert property (disable iff (1'b0) !rst_n && ce |=>
    modeSelect == 3'h0 && gainCode == 3'h0 && !inputSelect && !sleepRequest && !outputWordSize
    && notchCode == 12'h146 && resultReadyN && !serialDataOe) else $error("bad reset value");
  a_gain_pow2: assert property (pgaGain == (8'h01 << gainCode))
    else $error("gain not two to code");
  a_frame_hold: assert property (!transmitFrameN [*5] |-> $stable(gainCode)
    && $stable(notchCode) && $stable(inputSelect)) else $error("control changed in frame");
  a_cal_ready: assert property (seqCalRun ##1 seqCalEnd |-> !resultReadyN)
    else $error("calibration end not flagged");
  a_cal_bound: assert property (calCnt_r <= 2 * (notchCode * NOTCH_CYCLES + 1) + 16)
    else $error("calibration too long");
  a_bg_hold: assert property (modeSelect == 3'h5 && !transmitFrameN |=> modeSelect == 3'h5)
    else $error("background mode dropped");
  a_read_drive: assert property ($fell(receiveFrameN) && !registerSelectLine
    |-> ##[2:6] serialDataOe) else $error("control read not driven");
  a_idle_release: assert property (receiveFrameN [*8] |-> !serialDataOe)
    else $error("pin driven outside read");
  a_ready_rise: assert property ($rose(resultReadyN) |-> !receiveFrameN && registerSelectLine)
    else $error("ready rose without result read");
endmodule
bind adc_mode_calibration_control adc_mode_calibration_control_asserts #(
  .NOTCH_CYCLES(NOTCH_CYCLES)
) asserts_inst (
  .clk(clk), .rst_n(rst_n), .ce(ce), .transmitFrameN(transmitFrameN),
  .receiveFrameN(receiveFrameN), .registerSelectLine(registerSelectLine),
  .serialDataOe(serialDataOe), .resultReadyN(resultReadyN), .gainCode(gainCode),
  .pgaGain(pgaGain), .inputSelect(inputSelect), .sleepRequest(sleepRequest),
  .outputWordSize(outputWordSize), .notchCode(notchCode), .modeSelect(modeSelect)
);

// ### dv/adc_mode_calibration_control_tb_top.sv
`timescale 1ns/1ps
module adc_mode_calibration_control_tb_top;
  localparam [11:0] NT = 12'h028;
  typedef struct {string name; logic [23:0] val; logic [23:0] mask;} note_t;
  note_t notes[$];
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [23:0] analogWord = 24'h000000;
  logic [23:0] shortedWord = 24'h000000;
  logic [23:0] referenceWord = 24'h000000;
  logic gapVld = 1'b0;
  logic [23:0] gapVal = 24'h000000;
  logic [23:0] zc [2];
  logic [23:0] fc [2];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  wire serialClk, transmitFrameN, receiveFrameN, registerSelectLine, hostData, rdDone;
  wire serialDataOut, serialDataOe, resultReadyN, inputSelect, sleepRequest;
  wire outputWordSize, burnoutSourceEnable, polaritySelect;
  wire [2:0] gainCode, modeSelect;
  wire [7:0] pgaGain;
  wire [11:0] notchCode;
  wire [23:0] rdWord;
  // shared data pin, the device wins while it drives
  wire dataPin = serialDataOe ? serialDataOut : hostData;
  always #20 clk = ~clk;
  adc_mode_calibration_control #(.NOTCH_CYCLES(12'h001)) adc_mode_calibration_control_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .serialClk(serialClk), .transmitFrameN(transmitFrameN),
    .receiveFrameN(receiveFrameN), .registerSelectLine(registerSelectLine),
    .serialDataIn(dataPin), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .analogWord(analogWord), .shortedWord(shortedWord), .referenceWord(referenceWord),
    .resultReadyN(resultReadyN), .gainCode(gainCode), .pgaGain(pgaGain),
    .inputSelect(inputSelect), .sleepRequest(sleepRequest), .outputWordSize(outputWordSize),
    .burnoutSourceEnable(burnoutSourceEnable), .polaritySelect(polaritySelect),
    .notchCode(notchCode), .modeSelect(modeSelect));
  host_link_model host_link_model_inst (.clk(clk), .dataPin(dataPin), .serialClk(serialClk),
    .transmitFrameN(transmitFrameN), .receiveFrameN(receiveFrameN),
    .registerSelectLine(registerSelectLine), .hostData(hostData), .rdDone(rdDone),
    .rdWord(rdWord));
  // oldest note against each finished read or measured gap
  always @(posedge clk) begin
    note_t n;
    logic [23:0] got;
    if ((rdDone || gapVld) && notes.size() != 0) begin
      n = notes.pop_front();
      got = gapVld ? gapVal : rdWord;
      checks_done++;
      if ((got & n.mask) !== (n.val & n.mask)) begin
        err_total++;
        $display("ERROR %s expected %h seen %h", n.name, n.val & n.mask, got & n.mask);
      end
    end
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [23:0] cw(input logic [2:0] m, input logic [2:0] g, input logic ch,
    input logic pd, input logic wl);
    return {m, g, ch, pd, wl, 1'b0, wl, ch, NT};
  endfunction
  task automatic wr(input logic sel, input logic [23:0] w, input int n);
    host_link_model_inst.xfer(1'b0, sel, w, n);
  endtask
  task automatic rd(input string s, input logic sel, input int n, input logic [23:0] v);
    notes.push_back('{s, v, !sel ? 24'hFFBFFF : n == 24 ? 24'hFFFFFF : 24'h00FFFF});
    host_link_model_inst.xfer(1'b1, sel, 24'h000000, n);
  endtask
  // note an expected value and hand the seen value to the comparing process
  task automatic put(input string s, input logic [23:0] e, input logic [23:0] got);
    notes.push_back('{s, e, 24'hFFFFFF});
    gapVal <= got;
    gapVld <= 1'b1;
    @(posedge clk);
    gapVld <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_for(input logic rdy);
    int t;
    for (t = 0; t < 2000 && (rdy ? resultReadyN !== 1'b0 : modeSelect !== 3'h0); t++)
      @(posedge clk);
  endtask
  task automatic chk_coefs(input logic ch);
    wr(1'b0, cw(3'h6, 3'h0, ch, 1'b0, 1'b0), 24);
    rd("zero coef", 1'b1, 24, zc[ch]);
    wr(1'b0, cw(3'h7, 3'h0, ch, 1'b0, 1'b0), 24);
    rd("full coef", 1'b1, 24, fc[ch]);
  endtask
  task automatic res(input logic wl);
    wr(1'b0, cw(3'h0, 3'h0, 1'b0, 1'b0, wl), 24);
    repeat (100) @(posedge clk);
    wait_for(1'b1);
    rd("result", 1'b1, wl ? 24 : 16, wl ? analogWord : {8'h00, analogWord[23:8]});
  endtask
  initial begin
    int g, t1;
    logic [23:0] v;
    v = $urandom(32'hC660);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd("reset ctrl", 1'b0, 24, 24'h000146);
    for (g = 0; g < 8; g++) begin
      v = cw(3'h0, g[2:0], g[0], g == 3, g[1]);
      wr(1'b0, v, g == 7 ? 28 : 24);
      rd("ctrl", 1'b0, 24, v);
      put("ctrl pins", v, {modeSelect, gainCode, inputSelect, sleepRequest, outputWordSize, 1'b0,
        burnoutSourceEnable, polaritySelect, notchCode});
      put("pga gain", {16'h0000, 8'h01 << g[2:0]}, {16'h0000, pgaGain});
    end
    wr(1'b0, ~v, 12);
    rd("ctrl kept", 1'b0, 24, v);
    // every coefficient slot written, a short write after it
    for (g = 0; g < 4; g++) begin
      wr(1'b0, cw({2'b11, g[1]}, 3'h0, g[0], 1'b0, 1'b0), 24);
      v = 24'($urandom);
      if (g[1]) fc[g[0]] = v;
      else zc[g[0]] = v;
      wr(1'b1, v, 24);
      wr(1'b1, ~v, 20);
      rd("coef", 1'b1, 24, v);
    end
    // each one-shot calibration on a random channel
    for (g = 1; g < 5; g++) begin
      v = 24'($urandom);
      analogWord <= 24'($urandom);
      shortedWord <= 24'($urandom);
      referenceWord <= 24'($urandom);
      wr(1'b0, cw(g[2:0], 3'h1, v[0], 1'b0, 1'b0), 24);
      wait_for(1'b0);
      if (g != 3) zc[v[0]] = g == 1 ? shortedWord : analogWord;
      if (g != 2) fc[v[0]] = g == 3 ? analogWord : referenceWord;
      rd("ctrl after cal", 1'b0, 24, cw(3'h0, 3'h1, v[0], 1'b0, 1'b0));
      chk_coefs(v[0]);
    end
    analogWord <= 24'($urandom);
    res(1'b0);
    res(1'b1);
    wr(1'b0, cw(3'h5, 3'h0, 1'b0, 1'b0, 1'b0), 24);
    shortedWord <= 24'($urandom);
    referenceWord <= 24'($urandom);
    wait_for(1'b1);
    rd("bg result", 1'b1, 16, {8'h00, analogWord[23:8]});
    wait_for(1'b1);
    t1 = cycles;
    rd("bg result", 1'b1, 16, {8'h00, analogWord[23:8]});
    wait_for(1'b1);
    put("bg period", 24'(6 * NT + 1), 24'(cycles - t1));
    zc[0] = shortedWord;
    fc[0] = referenceWord;
    chk_coefs(1'b0);
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule

// ### dv/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  input wire clk,
  input wire dataPin,
  output logic serialClk,
  output logic transmitFrameN,
  output logic receiveFrameN,
  output logic registerSelectLine,
  output logic hostData,
  output logic rdDone,
  output logic [23:0] rdWord
);
  // idle link: clock parked low, both frames high
  initial begin
    serialClk = 1'b0;
    transmitFrameN = 1'b1;
    receiveFrameN = 1'b1;
    registerSelectLine = 1'b0;
    hostData = 1'b0;
    rdDone = 1'b0;
    rdWord = 24'h000000;
  end
  // one frame of n pulses, msb first, 320 ns link period
  task automatic xfer(input logic rd, input logic sel, input logic [23:0] w, input int n);
    int i;
    @(posedge clk);
    registerSelectLine <= sel;
    transmitFrameN <= rd;
    receiveFrameN <= !rd;
    rdWord <= 24'h000000;
    repeat (8) @(posedge clk);
    for (i = 0; i < n; i++) begin
      hostData <= rd ? !hostData : w[(47 - i) % 24];
      repeat (4) @(posedge clk);
      serialClk <= 1'b1;
      repeat (4) @(posedge clk);
      rdWord <= {rdWord[22:0], dataPin};
      serialClk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    transmitFrameN <= 1'b1;
    receiveFrameN <= 1'b1;
    hostData <= !hostData;
    repeat (8) @(posedge clk);
    rdDone <= rd;
    @(posedge clk);
    rdDone <= 1'b0;
  endtask
endmodule

// ### hdl/adc_ctrl_regs.vh
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// control word field positions, most significant bit first
`define CW_WIDTH 24
`define CW_MODE_HI 23
`define CW_MODE_LO 21
`define CW_GAIN_HI 20
`define CW_GAIN_LO 18
`define CW_CH_BIT 17
`define CW_PD_BIT 16
`define CW_WL_BIT 15
`define CW_X_BIT 14
`define CW_BO_BIT 13
`define CW_BU_BIT 12
`define CW_NOTCH_HI 11
`define CW_NOTCH_LO 0

// operating mode codes
`define MODE_NORMAL 3'h0
`define MODE_SELF_CAL 3'h1
`define MODE_SYS_ZERO 3'h2
`define MODE_SYS_FULL 3'h3
`define MODE_SYS_OFFSET 3'h4
`define MODE_BACKGROUND 3'h5
`define MODE_RW_ZERO 3'h6
`define MODE_RW_FULL 3'h7

// reset values of the control fields
`define MODE_RST 3'h0
`define GAIN_RST 3'h0
`define CH_RST 1'h0
`define PD_RST 1'h0
`define WL_RST 1'h0
`define BO_RST 1'h0
`define BU_RST 1'h0
`define NOTCH_RST 12'h146
`define PGA_GAIN_RST 8'h01

// coefficient store addressing: {kind, channel}
`define COEF_AW 2
`define COEF_KIND_ZERO 1'h0
`define COEF_KIND_FULL 1'h1

// transfer lengths and timing
`define COEF_BITS 5'h18
`define CTRL_BITS 5'h18
`define SHORT_WORD_BITS 5'h10
`define LONG_WORD_BITS 5'h18
`define BG_RATE_FACTOR 3'h6
`define NOTCH_CYCLES_RST 12'h200

`endif

// ### hdl/adc_mode_calibration_control.v
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
// Function
// - mode zero is normal operation and the reset mode
// - mode one self-calibrates zero then full scale, clears mode, flags completion
// - mode two runs system zero-scale calibration, flags completion, returns normal
// - mode three runs system full-scale calibration, flags completion, returns normal
// - mode four zero on input, full on reference, then normal
// - mode five interleaves calibration, conversion period six times longer
// - background mode updates coefficients automatically every conversion
// - mode six maps select-high accesses to zero-scale coefficient of channel
// - mode seven maps select-high accesses to full-scale coefficient of channel
// - coefficient transfers are always 24 bits
// - short coefficient write is discarded
// - gain is two to the gain code, default one
// - channel select picks input for calibration and coefficients, default low
// - control word needs exactly 24 bits, extra clocks ignored
// - ready falls on new word or calibration end, rises after readout
// - sleep bit stops conversions, default awake
// - word size bit chooses 16 or 24 bit results, default 16
module adc_mode_calibration_control #(
  parameter [11:0] NOTCH_CYCLES = `NOTCH_CYCLES_RST
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire serialClk,
  input wire transmitFrameN,
  input wire receiveFrameN,
  input wire registerSelectLine,
  input wire serialDataIn,
  output wire serialDataOut,
  output wire serialDataOe,
  input wire [23:0] analogWord,
  input wire [23:0] shortedWord,
  input wire [23:0] referenceWord,
  output wire resultReadyN,
  output wire [2:0] gainCode,
  output wire [7:0] pgaGain,
  output wire inputSelect,
  output wire sleepRequest,
  output wire outputWordSize,
  output wire burnoutSourceEnable,
  output wire polaritySelect,
  output wire [11:0] notchCode,
  output wire [2:0] modeSelect
);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ZERO = 3'h2;
  localparam [2:0] ST_FULL = 3'h4;

  reg [4:0] syncA_r;
  reg [4:0] syncB_r;
  reg prevSclk_r;
  reg prevTfs_r;
  reg prevRfs_r;
  reg [23:0] ctrl_r;
  reg [7:0] pgaGain_r;
  reg [23:0] wrShift_r;
  reg [4:0] wrCnt_r;
  reg [23:0] rdShift_r;
  reg [4:0] rdCnt_r;
  reg [4:0] rdLen_r;
  reg rdActive_r;
  reg rdIsData_r;
  reg sdataOut_r;
  reg sdataOe_r;
  reg resultReadyN_r;
  reg [23:0] data_r;
  reg [2:0] state_r;
  reg [23:0] timer_r;
  reg memWe;
  reg [1:0] memWaddr;
  reg [23:0] memWdata;
  wire [23:0] memRdata;

  // synchronised link pins: 0 clock, 1 write frame, 2 read frame, 3 data, 4 select
  wire sclkS = syncB_r[0];
  wire tfsS = syncB_r[1];
  wire rfsS = syncB_r[2];
  wire sdinS = syncB_r[3];
  wire a0S = syncB_r[4];
  wire sclkRise = sclkS & ~prevSclk_r;
  wire sclkFall = ~sclkS & prevSclk_r;
  wire tfsFall = ~tfsS & prevTfs_r;
  wire tfsRise = tfsS & ~prevTfs_r;
  wire rfsFall = ~rfsS & prevRfs_r;
  wire rfsRise = rfsS & ~prevRfs_r;

  wire [2:0] mode = ctrl_r[`CW_MODE_HI:`CW_MODE_LO];
  wire chSel = ctrl_r[`CW_CH_BIT];
  wire coefMode = (mode == `MODE_RW_ZERO) || (mode == `MODE_RW_FULL);
  wire [2:0] newMode = wrShift_r[`CW_MODE_HI:`CW_MODE_LO];
  wire [23:0] stepLen = ctrl_r[`CW_NOTCH_HI:`CW_NOTCH_LO] * NOTCH_CYCLES;
  wire [23:0] newStepLen = wrShift_r[`CW_NOTCH_HI:`CW_NOTCH_LO] * NOTCH_CYCLES;
  wire [23:0] bgLen = stepLen * `BG_RATE_FACTOR;
  wire [23:0] convLen = (mode == `MODE_BACKGROUND) ? bgLen : stepLen;

  wire wrDone = tfsRise && (wrCnt_r == `CTRL_BITS);
  wire ctrlWrite = wrDone && !a0S;
  wire coefWrite = wrDone && a0S && coefMode && (wrCnt_r == `COEF_BITS);
  wire calStart = ctrlWrite && !wrShift_r[`CW_PD_BIT] && (newMode != `MODE_NORMAL) &&
    (newMode <= `MODE_SYS_OFFSET);

  wire tick = (timer_r == 24'h000000);
  wire convRun = state_r[0] && !ctrl_r[`CW_PD_BIT];
  wire convTick = convRun && tick;
  wire bgZeroTick = convRun && (mode == `MODE_BACKGROUND) && (timer_r == 24'h000001);
  wire zeroTick = state_r[1] && tick;
  wire fullTick = state_r[2] && tick;
  wire zeroThenFull = (mode == `MODE_SELF_CAL) || (mode == `MODE_SYS_OFFSET);
  wire calFinish = fullTick || (zeroTick && !zeroThenFull);
  wire dataReadDone = rdActive_r && sclkFall && rdIsData_r && (rdCnt_r + 5'h01 == rdLen_r);

  // two-stage synchroniser for every link pin
  always @(posedge clk) begin
    if (!rst_n) begin
      // link clock idles low, frames and select idle high
      syncA_r <= 5'h1E;
      syncB_r <= 5'h1E;
    end else if (ce) begin
      syncA_r <= {registerSelectLine, serialDataIn, receiveFrameN, transmitFrameN, serialClk};
      syncB_r <= syncA_r;
    end
  end

  // previous synchronised levels for edge detection
  always @(posedge clk) begin
    if (!rst_n) begin
      prevSclk_r <= 1'b0;
      prevTfs_r <= 1'b1;
      prevRfs_r <= 1'b1;
    end else if (ce) begin
      prevSclk_r <= sclkS;
      prevTfs_r <= tfsS;
      prevRfs_r <= rfsS;
    end
  end

  // write shifter: data taken on rising link clock while write frame is low
  always @(posedge clk) begin
    if (!rst_n) begin
      wrShift_r <= 24'h000000;
      wrCnt_r <= 5'h00;
    end else if (ce) begin
      if (tfsFall) begin
        wrCnt_r <= 5'h00;
      end else if (!tfsS && sclkRise && (wrCnt_r != `CTRL_BITS)) begin
        wrShift_r <= {wrShift_r[22:0], sdinS};
        wrCnt_r <= wrCnt_r + 5'h01;
      end
    end
  end

  // control word register and derived gain
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= {`MODE_RST, `GAIN_RST, `CH_RST, `PD_RST, `WL_RST, 1'b0, `BO_RST, `BU_RST,
        `NOTCH_RST};
      pgaGain_r <= `PGA_GAIN_RST;
    end else if (ce) begin
      if (ctrlWrite) begin
        ctrl_r <= wrShift_r;
        pgaGain_r <= 8'h01 << wrShift_r[`CW_GAIN_HI:`CW_GAIN_LO];
      end else if (calFinish) begin
        ctrl_r[`CW_MODE_HI:`CW_MODE_LO] <= `MODE_NORMAL;
      end
    end
  end

  // calibration sequencer and shared conversion timer
  always @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      timer_r <= 24'h000000;
    end else if (ce) begin
      if (calStart) begin
        state_r <= (newMode == `MODE_SYS_FULL) ? ST_FULL : ST_ZERO;
        timer_r <= newStepLen;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (convRun) begin
              timer_r <= tick ? convLen : timer_r - 24'h000001;
            end
          end
          ST_ZERO: begin
            if (tick) begin
              state_r <= zeroThenFull ? ST_FULL : ST_IDLE;
              timer_r <= zeroThenFull ? stepLen : convLen;
            end else begin
              timer_r <= timer_r - 24'h000001;
            end
          end
          ST_FULL: begin
            if (tick) begin
              state_r <= ST_IDLE;
              timer_r <= stepLen;
            end else begin
              timer_r <= timer_r - 24'h000001;
            end
          end
          default: begin
            state_r <= ST_IDLE;
            timer_r <= 24'h000000;
          end
        endcase
      end
    end
  end

  // coefficient write port: host first, then calibration, then background
  always @* begin
    memWe = 1'b0;
    memWaddr = {`COEF_KIND_ZERO, chSel};
    memWdata = wrShift_r;
    if (coefWrite) begin
      memWe = 1'b1;
      memWaddr = {mode[0], chSel};
    end else if (zeroTick) begin
      memWe = 1'b1;
      memWdata = (mode == `MODE_SELF_CAL) ? shortedWord : analogWord;
    end else if (fullTick) begin
      memWe = 1'b1;
      memWaddr = {`COEF_KIND_FULL, chSel};
      memWdata = (mode == `MODE_SYS_FULL) ? analogWord : referenceWord;
    end else if (bgZeroTick) begin
      memWe = 1'b1;
      memWdata = shortedWord;
    end else if (convTick && (mode == `MODE_BACKGROUND)) begin
      memWe = 1'b1;
      memWaddr = {`COEF_KIND_FULL, chSel};
      memWdata = referenceWord;
    end
  end

  coef_mem #(
    .WIDTH(24),
    .AW(`COEF_AW)
  ) u_coef_mem (
    .clk(clk),
    .ce(ce),
    .we(memWe),
    .waddr(memWaddr),
    .wdata(memWdata),
    .raddr({mode[0], chSel}),
    .rdata(memRdata)
  );

  // conversion result register
  always @(posedge clk) begin
    if (!rst_n) begin
      data_r <= 24'h000000;
    end else if (ce && convTick) begin
      data_r <= analogWord;
    end
  end

  // ready flag, a new word wins over the readout clear
  always @(posedge clk) begin
    if (!rst_n) begin
      resultReadyN_r <= 1'b1;
    end else if (ce) begin
      if (convTick || calFinish) begin
        resultReadyN_r <= 1'b0;
      end else if (dataReadDone) begin
        resultReadyN_r <= 1'b1;
      end
    end
  end

  // read shifter: first bit on read frame fall, next bits on falling link clock
  always @(posedge clk) begin
    if (!rst_n) begin
      rdShift_r <= 24'h000000;
      rdCnt_r <= 5'h00;
      rdLen_r <= 5'h00;
      rdActive_r <= 1'b0;
      rdIsData_r <= 1'b0;
      sdataOut_r <= 1'b0;
      sdataOe_r <= 1'b0;
    end else if (ce) begin
      if (rfsFall) begin
        rdCnt_r <= 5'h00;
        rdIsData_r <= 1'b0;
        if (!a0S) begin
          rdShift_r <= ctrl_r;
          rdLen_r <= `CTRL_BITS;
          rdActive_r <= 1'b1;
          sdataOut_r <= ctrl_r[23];
          sdataOe_r <= 1'b1;
        end else if (coefMode) begin
          rdShift_r <= memRdata;
          rdLen_r <= `COEF_BITS;
          rdActive_r <= 1'b1;
          sdataOut_r <= memRdata[23];
          sdataOe_r <= 1'b1;
        end else if (!resultReadyN_r) begin
          rdShift_r <= ctrl_r[`CW_WL_BIT] ? data_r : {data_r[23:8], 8'h00};
          rdLen_r <= ctrl_r[`CW_WL_BIT] ? `LONG_WORD_BITS : `SHORT_WORD_BITS;
          rdIsData_r <= 1'b1;
          rdActive_r <= 1'b1;
          sdataOut_r <= data_r[23];
          sdataOe_r <= 1'b1;
        end else begin
          rdActive_r <= 1'b0;
          sdataOe_r <= 1'b0;
        end
      end else if (rfsRise) begin
        rdActive_r <= 1'b0;
        sdataOe_r <= 1'b0;
      end else if (rdActive_r && sclkFall) begin
        if (rdCnt_r + 5'h01 == rdLen_r) begin
          rdActive_r <= 1'b0;
          sdataOe_r <= 1'b0;
        end else begin
          rdShift_r <= {rdShift_r[22:0], 1'b0};
          sdataOut_r <= rdShift_r[22];
          rdCnt_r <= rdCnt_r + 5'h01;
        end
      end
    end
  end

  // outputs straight from registers
  assign serialDataOut = sdataOut_r;
  assign serialDataOe = sdataOe_r;
  assign resultReadyN = resultReadyN_r;
  assign modeSelect = ctrl_r[`CW_MODE_HI:`CW_MODE_LO];
  assign gainCode = ctrl_r[`CW_GAIN_HI:`CW_GAIN_LO];
  assign pgaGain = pgaGain_r;
  assign inputSelect = ctrl_r[`CW_CH_BIT];
  assign sleepRequest = ctrl_r[`CW_PD_BIT];
  assign outputWordSize = ctrl_r[`CW_WL_BIT];
  assign burnoutSourceEnable = ctrl_r[`CW_BO_BIT];
  assign polaritySelect = ctrl_r[`CW_BU_BIT];
  assign notchCode = ctrl_r[`CW_NOTCH_HI:`CW_NOTCH_LO];
endmodule

// ### hdl/coef_mem.v
`timescale 1ns/1ps
// small coefficient store with registered read data
module coef_mem #(
  parameter WIDTH = 24,
  parameter AW = 2
) (
  input wire clk,
  input wire ce,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // write and registered read, frozen when ce is low
  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule
